// ===== hdl/crm_core.sv
// programmer-visible register set with an axi4-lite register port
// Operation
// - accumulator takes and feeds alu results
// - two index registers add to base
// - pre- and post-indexed indirect addressing
// - stack pointer addresses page 100h-1ffh
// - push decrements, pull increments stack pointer
// - program counter drives address bus bytes
// - program counter increments per fetched byte
// - eight-bit status register, seven flags
// - branches test one status flag
// - status bit two masks interrupts
// - status bit four marks break entry
// - reset two cycles; six-cycle initialisation
// - init sets i, clears d, loads vector
// - interrupt pushes pc, status, sets mask
module crm_core
    import crm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic irq_request,
    output logic [15:0] addr_bus,
    output logic [7:0] data_out,
    output logic data_write,
    input wire logic [7:0] data_in,
    output logic running
);
    typedef enum logic [1:0] {CRM_ST_INIT, CRM_ST_VEC_LO, CRM_ST_VEC_HI, CRM_ST_RUN} crm_state_t;
    typedef enum logic [1:0] {CRM_ENT_IDLE, CRM_ENT_PCH, CRM_ENT_PCL, CRM_ENT_P} crm_entry_t;

    crm_state_t state_reg, state_next;
    crm_entry_t entry_reg, entry_next;
    logic [2:0] init_reg, init_next;
    logic [7:0] acc_reg, acc_next, idx_x_reg, idx_x_next, idx_y_reg, idx_y_next;
    logic [7:0] sp_reg, sp_next, p_reg, p_next;
    logic [15:0] program_counter_reg, program_counter_next;
    logic [15:0] vec_reg, vec_next, ea_reg, ea_next;
    logic [7:0] opnd_reg, opnd_next;
    logic brk_reg, brk_next;
    logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
    logic [7:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic irq_s1_reg, irq_s2_reg;
    logic [7:0] alu_res;
    logic alu_c, alu_v;
    logic [3:0] op_cmd;
    logic [7:0] program_counter_low_byte, program_counter_high_byte;
    logic wr_go, rd_go, cmd_go;
    logic [7:0] idx_sel;

    assign program_counter_low_byte = program_counter_reg[7:0];
    assign program_counter_high_byte = program_counter_reg[15:8];

    crm_alu u_alu (
        .op(op_cmd),
        .a(acc_reg),
        .b(wd_reg[7:0]),
        .carry_in(p_reg[CRM_BIT_C]),
        .result(alu_res),
        .carry_out(alu_c),
        .overflow(alu_v)
    );

    // the request pin is asynchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_s1_reg <= 1'b0;
            irq_s2_reg <= 1'b0;
        end else if (ce) begin
            irq_s1_reg <= irq_request;
            irq_s2_reg <= irq_s1_reg;
        end
    end

    assign awready = !aw_reg && !bv_reg;
    assign wready = !w_reg && !bv_reg;
    assign arready = !rv_reg;
    assign bvalid = bv_reg;
    assign bresp = br_reg;
    assign rvalid = rv_reg;
    assign rresp = rr_reg;
    assign rdata = rd_reg;
    assign running = (state_reg == CRM_ST_RUN);
    assign wr_go = aw_reg && w_reg && !bv_reg;
    assign rd_go = arvalid && !rv_reg;
    // register writes wait while an interrupt entry owns the stack
    assign cmd_go = wr_go && running && (entry_reg == CRM_ENT_IDLE);
    assign op_cmd = wd_reg[3:0];

    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        if (awvalid && awready) begin
            aw_next = 1'b1;
            awa_next = awaddr;
        end
        if (wvalid && wready) begin
            w_next = 1'b1;
            wd_next = wdata;
        end
        if (cmd_go || (wr_go && !running)) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = CRM_RESP_OK;
            if (!running || awa_next > CRM_OFF_EA) begin
                br_next = CRM_RESP_ERR;
            end
        end
        if (bv_reg && bready) begin
            bv_next = 1'b0;
        end
        if (rd_go) begin
            rv_next = 1'b1;
            rr_next = CRM_RESP_OK;
            rd_next = 32'h0000_0000;
            unique case (araddr)
                CRM_OFF_A: rd_next[7:0] = acc_reg;
                CRM_OFF_X: rd_next[7:0] = idx_x_reg;
                CRM_OFF_Y: rd_next[7:0] = idx_y_reg;
                CRM_OFF_S: rd_next[7:0] = sp_reg;
                CRM_OFF_PC: rd_next[15:0] = program_counter_reg;
                CRM_OFF_P: rd_next[7:0] = p_reg;
                CRM_OFF_OP: rd_next[7:0] = opnd_reg;
                CRM_OFF_EA: rd_next[15:0] = ea_reg;
                CRM_OFF_STAT: rd_next[2:0] = {brk_reg, entry_reg != CRM_ENT_IDLE, running};
                default: rr_next = CRM_RESP_ERR;
            endcase
        end else if (rv_reg && rready) begin
            rv_next = 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        entry_next = entry_reg;
        init_next = init_reg;
        acc_next = acc_reg;
        idx_x_next = idx_x_reg;
        idx_y_next = idx_y_reg;
        sp_next = sp_reg;
        p_next = p_reg;
        program_counter_next = program_counter_reg;
        vec_next = vec_reg;
        ea_next = ea_reg;
        opnd_next = opnd_reg;
        brk_next = brk_reg;
        addr_bus = program_counter_reg;
        data_out = 8'h00;
        data_write = 1'b0;
        idx_sel = wd_reg[8] ? idx_y_reg : idx_x_reg;
        p_next[CRM_BIT_ONE] = 1'b1;
        unique case (state_reg)
            CRM_ST_INIT: begin
                init_next = init_reg + 3'h1;
                if (init_reg == CRM_INIT_LAST) begin
                    state_next = CRM_ST_VEC_LO;
                    p_next[CRM_BIT_I] = 1'b1;
                    p_next[CRM_BIT_D] = 1'b0;
                end
            end
            CRM_ST_VEC_LO: begin
                addr_bus = CRM_VEC_RESET;
                program_counter_next[7:0] = data_in;
                state_next = CRM_ST_VEC_HI;
            end
            CRM_ST_VEC_HI: begin
                addr_bus = CRM_VEC_RESET + 16'h0001;
                program_counter_next[15:8] = data_in;
                state_next = CRM_ST_RUN;
            end
            CRM_ST_RUN: begin
                unique case (entry_reg)
                    CRM_ENT_IDLE: begin
                        // masked requests wait; a break entry ignores the mask
                        if (irq_s2_reg && !p_reg[CRM_BIT_I]) begin
                            entry_next = CRM_ENT_PCH;
                            brk_next = 1'b0;
                            vec_next = CRM_VEC_IRQ;
                        end
                    end
                    CRM_ENT_PCH: begin
                        addr_bus = {CRM_STACK_PAGE, sp_reg};
                        data_out = program_counter_high_byte;
                        data_write = 1'b1;
                        sp_next = sp_reg - 8'h01;
                        entry_next = CRM_ENT_PCL;
                    end
                    CRM_ENT_PCL: begin
                        addr_bus = {CRM_STACK_PAGE, sp_reg};
                        data_out = program_counter_low_byte;
                        data_write = 1'b1;
                        sp_next = sp_reg - 8'h01;
                        entry_next = CRM_ENT_P;
                    end
                    CRM_ENT_P: begin
                        addr_bus = {CRM_STACK_PAGE, sp_reg};
                        data_out = p_reg;
                        data_out[CRM_BIT_B] = brk_reg;
                        data_write = 1'b1;
                        sp_next = sp_reg - 8'h01;
                        p_next[CRM_BIT_I] = 1'b1;
                        program_counter_next = vec_reg;
                        entry_next = CRM_ENT_IDLE;
                    end
                endcase
            end
        endcase
        if (cmd_go) begin
            unique case (awa_reg)
                CRM_OFF_A: acc_next = wd_reg[7:0];
                CRM_OFF_X: idx_x_next = wd_reg[7:0];
                CRM_OFF_Y: idx_y_next = wd_reg[7:0];
                CRM_OFF_S: sp_next = wd_reg[7:0];
                CRM_OFF_PC: program_counter_next = wd_reg[15:0];
                CRM_OFF_P: p_next = wd_reg[7:0] | CRM_P_RESET & 8'h20;
                CRM_OFF_EA: begin
                    // base in [31:16], mode in [10:9], index select in [8]
                    unique case (wd_reg[10:9])
                        CRM_AM_ABSX: ea_next = wd_reg[31:16] + {8'h00, idx_x_reg};
                        CRM_AM_ABSY: ea_next = wd_reg[31:16] + {8'h00, idx_y_reg};
                        CRM_AM_PREX: ea_next = {8'h00, wd_reg[23:16] + idx_sel};
                        CRM_AM_POSTY: ea_next = {data_in, opnd_reg} + {8'h00, idx_sel};
                    endcase
                end
                CRM_OFF_OP: begin
                    unique case (crm_op_t'(op_cmd))
                        CRM_OP_ADC, CRM_OP_SBC, CRM_OP_AND, CRM_OP_ORA, CRM_OP_EOR: begin
                            acc_next = alu_res;
                            p_next[CRM_BIT_N] = alu_res[7];
                            p_next[CRM_BIT_Z] = (alu_res == 8'h00);
                            if (op_cmd == CRM_OP_ADC || op_cmd == CRM_OP_SBC) begin
                                p_next[CRM_BIT_C] = alu_c;
                                p_next[CRM_BIT_V] = alu_v;
                            end
                        end
                        CRM_OP_PUSH: begin
                            addr_bus = {CRM_STACK_PAGE, sp_reg};
                            data_out = acc_reg;
                            data_write = 1'b1;
                            sp_next = sp_reg - 8'h01;
                        end
                        CRM_OP_PULL: begin
                            sp_next = sp_reg + 8'h01;
                            addr_bus = {CRM_STACK_PAGE, sp_next};
                            acc_next = data_in;
                        end
                        CRM_OP_FETCH: begin
                            opnd_next = data_in;
                            program_counter_next = program_counter_reg + 16'h0001;
                        end
                        CRM_OP_BRANCH: begin
                            // flag number in [14:12], wanted level in [15], offset in [31:24]
                            if (p_reg[wd_reg[14:12]] == wd_reg[15]) begin
                                program_counter_next = program_counter_reg
                                    + {{8{wd_reg[31]}}, wd_reg[31:24]};
                            end
                        end
                        CRM_OP_BRK: begin
                            entry_next = CRM_ENT_PCH;
                            brk_next = 1'b1;
                            vec_next = CRM_VEC_BRK;
                        end
                        CRM_OP_IRQ: begin
                            if (!p_reg[CRM_BIT_I]) begin
                                entry_next = CRM_ENT_PCH;
                                brk_next = 1'b0;
                                vec_next = CRM_VEC_IRQ;
                            end
                        end
                        CRM_OP_SEI: p_next[CRM_BIT_I] = 1'b1;
                        CRM_OP_CLI: p_next[CRM_BIT_I] = 1'b0;
                        CRM_OP_SED: p_next[CRM_BIT_D] = 1'b1;
                        CRM_OP_CLD: p_next[CRM_BIT_D] = 1'b0;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // stack pointer has no reset value: software must load it
    always_ff @(posedge aclk) begin
        if (ce) begin
            sp_reg <= sp_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= CRM_ST_INIT;
            entry_reg <= CRM_ENT_IDLE;
            init_reg <= 3'h0;
            acc_reg <= 8'h00;
            idx_x_reg <= 8'h00;
            idx_y_reg <= 8'h00;
            p_reg <= CRM_P_RESET;
            program_counter_reg <= 16'h0000;
            vec_reg <= CRM_VEC_RESET;
            ea_reg <= 16'h0000;
            opnd_reg <= 8'h00;
            brk_reg <= 1'b0;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            bv_reg <= 1'b0;
            rv_reg <= 1'b0;
            awa_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            rd_reg <= 32'h0000_0000;
            br_reg <= CRM_RESP_OK;
            rr_reg <= CRM_RESP_OK;
        end else if (ce) begin
            state_reg <= state_next;
            entry_reg <= entry_next;
            init_reg <= init_next;
            acc_reg <= acc_next;
            idx_x_reg <= idx_x_next;
            idx_y_reg <= idx_y_next;
            p_reg <= p_next;
            program_counter_reg <= program_counter_next;
            vec_reg <= vec_next;
            ea_reg <= ea_next;
            opnd_reg <= opnd_next;
            brk_reg <= brk_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            bv_reg <= bv_next;
            rv_reg <= rv_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
            br_reg <= br_next;
            rr_reg <= rr_next;
        end
    end
endmodule

// ===== hdl/crm_pkg.sv
// constants and types for the processor register model
package crm_pkg;
    localparam int CRM_W = 8;
    localparam int CRM_AW = 16;
    localparam logic [7:0] CRM_STACK_PAGE = 8'h01;
    localparam logic [15:0] CRM_VEC_RESET = 16'h7ffc;
    localparam logic [15:0] CRM_VEC_BRK = 16'h7ffe;
    localparam logic [15:0] CRM_VEC_IRQ = 16'h7ff8;
    localparam int CRM_INIT_CYCLES = 6;
    localparam logic [2:0] CRM_INIT_LAST = 3'h5;
    localparam int CRM_BIT_C = 0;
    localparam int CRM_BIT_Z = 1;
    localparam int CRM_BIT_I = 2;
    localparam int CRM_BIT_D = 3;
    localparam int CRM_BIT_B = 4;
    localparam int CRM_BIT_ONE = 5;
    localparam int CRM_BIT_V = 6;
    localparam int CRM_BIT_N = 7;
    localparam logic [7:0] CRM_P_RESET = 8'h24;
    // register offsets on the axi4-lite port
    localparam logic [7:0] CRM_OFF_A = 8'h00;
    localparam logic [7:0] CRM_OFF_X = 8'h04;
    localparam logic [7:0] CRM_OFF_Y = 8'h08;
    localparam logic [7:0] CRM_OFF_S = 8'h0c;
    localparam logic [7:0] CRM_OFF_PC = 8'h10;
    localparam logic [7:0] CRM_OFF_P = 8'h14;
    localparam logic [7:0] CRM_OFF_OP = 8'h18;
    localparam logic [7:0] CRM_OFF_EA = 8'h1c;
    localparam logic [7:0] CRM_OFF_STAT = 8'h20;
    localparam logic [1:0] CRM_RESP_OK = 2'h0;
    localparam logic [1:0] CRM_RESP_ERR = 2'h2;
    // operation codes written to the op register
    typedef enum logic [3:0] {
        CRM_OP_NOP = 4'h0, CRM_OP_ADC = 4'h1, CRM_OP_SBC = 4'h2, CRM_OP_AND = 4'h3,
        CRM_OP_ORA = 4'h4, CRM_OP_EOR = 4'h5, CRM_OP_PUSH = 4'h6, CRM_OP_PULL = 4'h7,
        CRM_OP_FETCH = 4'h8, CRM_OP_BRANCH = 4'h9, CRM_OP_BRK = 4'ha, CRM_OP_IRQ = 4'hb,
        CRM_OP_SEI = 4'hc, CRM_OP_CLI = 4'hd, CRM_OP_SED = 4'he, CRM_OP_CLD = 4'hf
    } crm_op_t;
    // address generation modes
    localparam logic [1:0] CRM_AM_ABSX = 2'h0;
    localparam logic [1:0] CRM_AM_ABSY = 2'h1;
    localparam logic [1:0] CRM_AM_PREX = 2'h2;
    localparam logic [1:0] CRM_AM_POSTY = 2'h3;
endpackage

// ===== hdl/crm_alu.sv
// arithmetic and logic unit with flag results
module crm_alu
    import crm_pkg::*;
(
    input wire logic [3:0] op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic overflow
);
    logic [8:0] sum;
    logic [7:0] operand;
    always_comb begin
        operand = (op == CRM_OP_SBC) ? ~b : b;
        sum = {1'b0, a} + {1'b0, operand} + {8'h00, carry_in};
        result = sum[7:0];
        carry_out = sum[8];
        overflow = (a[7] == operand[7]) && (sum[7] != a[7]);
        unique case (op)
            CRM_OP_AND: result = a & b;
            CRM_OP_ORA: result = a | b;
            CRM_OP_EOR: result = a ^ b;
            default: result = sum[7:0];
        endcase
    end
endmodule

// ===== test/crm_core_monitor.sv
// assertion checker for the processor register model core
module crm_core_monitor
    import crm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq_request,
    input wire logic [15:0] addr_bus,
    input wire logic [7:0] data_out,
    input wire logic data_write,
    input wire logic [7:0] data_in,
    input wire logic running
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rst_q;
    // remembers the reset edge, since the disable hides reset itself
    always_ff @(posedge aclk) begin
        rst_q <= !aresetn;
    end
    default clocking mclk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_RESET_IDLE: assert property (rst_q |-> !running && !bvalid && !rvalid && awready)
        else $error("outputs not idle right after reset");
    AST_INIT_ZERO: assert property ($rose(aresetn) |-> (!running && addr_bus == 16'h0000) [*6])
        else $error("initialisation shorter than six cycles");
    AST_RUN_BOUND: assert property ($rose(aresetn) |-> ##[7:12] running)
        else $error("core not running after initialisation");
    AST_VEC_FETCH: assert property ($rose(running) |->
        $past(addr_bus, 2) == CRM_VEC_RESET && $past(addr_bus) == CRM_VEC_RESET + 16'h0001)
        else $error("restart vector not read low then high");
    AST_STACK_PAGE: assert property (data_write |-> addr_bus[15:8] == CRM_STACK_PAGE)
        else $error("stack write outside stack page");
    AST_PUSH_DEC: assert property (data_write && $past(data_write) |->
        addr_bus[7:0] == $past(addr_bus[7:0]) - 8'h01)
        else $error("stack pointer not decremented per push");
    AST_ENTRY_ONE: assert property (data_write && $past(data_write) && $past(data_write, 2) |->
        data_out[CRM_BIT_ONE] == 1'b1)
        else $error("pushed status lacks constant one bit");
    AST_NO_WRITE_INIT: assert property (!running |-> !data_write)
        else $error("memory write before initialisation done");
    AST_READ_ANS: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
endmodule

bind crm_core crm_core_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq_request(irq_request), .addr_bus(addr_bus),
    .data_out(data_out), .data_write(data_write), .data_in(data_in), .running(running));

// ===== test/crm_mem_model.sv
// program and data memory on the core address bus
module crm_mem_model (
    input wire logic aclk,
    input wire logic [15:0] addr_bus,
    input wire logic [7:0] data_out,
    input wire logic data_write,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
        mem[16'h7ffc] = 8'h34;
        mem[16'h7ffd] = 8'h42;
        mem[16'h4234] = 8'h11;
        mem[16'h4235] = 8'h22;
    end
    // combinational read, no wait states
    assign data_in = mem[addr_bus];
    always @(posedge aclk) begin
        if (data_write) mem[addr_bus] <= data_out;
    end
endmodule

// ===== test/tb.sv
// register-level testbench for the processor register model
module tb
    import crm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, irq_request = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, data_write, running;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] addr_bus;
    logic [7:0] data_out, data_in;
    int failures = 0, n_compared = 0;
    logic [15:0] eb [4] = '{16'h1230, 16'h1230, 16'h0030, 16'h0000};
    logic es [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] ee [4] = '{16'h1235, 16'h1240, 16'h0035, 16'h2221};
    logic [7:0] ow [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h03};
    logic [7:0] oa [5] = '{8'h80, 8'h7d, 8'h7d, 8'h78, 8'h00};
    logic [7:0] opf [5] = '{8'he0, 8'h61, 8'h61, 8'h61, 8'h63};
    logic [7:0] fc [6] = '{8'h0e, 8'h0f, 8'h0d, 8'h0c, 8'h00, 8'h0b};
    logic [7:0] fp [6] = '{8'h2d, 8'h25, 8'h21, 8'h25, 8'h25, 8'h25};

    always #20 aclk = ~aclk;

    crm_core dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq_request(irq_request), .addr_bus(addr_bus), .data_out(data_out),
        .data_write(data_write), .data_in(data_in), .running(running));
    crm_mem_model mem_u (.aclk(aclk), .addr_bus(addr_bus), .data_out(data_out),
        .data_write(data_write), .data_in(data_in));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // handshake flags sampled mid-cycle: inputs only move at rising edges
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = CRM_RESP_OK);
        logic ta, tw, done;
        logic [1:0] r;
        int n;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 100) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (done !== 1'b1) r = 2'h3;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffffffff, input logic [1:0] er = CRM_RESP_OK);
        logic ta, done;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 100) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (done !== 1'b1) r = 2'h3;
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk(nm, e & m, d & m);
    endtask

    task automatic do_reset(input int n);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        axi_wr(CRM_OFF_A, 32'h99, CRM_RESP_ERR);
        n = 0;
        while (running !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        chk("running", 32'h1, {31'h0, running});
        rdchk("status", CRM_OFF_P, 32'h24);
        rdchk("pc", CRM_OFF_PC, 32'h4234);
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        print_verdict();
    end

    initial begin
        do_reset(20);
        rdchk("stat", CRM_OFF_STAT, 32'h1);
        $display("test reset done");
        axi_wr(CRM_OFF_S, 32'hff);
        axi_wr(CRM_OFF_X, 32'h05);
        axi_wr(CRM_OFF_Y, 32'h10);
        axi_wr(CRM_OFF_OP, 32'h8);
        rdchk("operand", CRM_OFF_OP, 32'h11);
        rdchk("pc", CRM_OFF_PC, 32'h4235);
        for (int i = 0; i < 4; i++) begin
            axi_wr(CRM_OFF_EA, {eb[i], 5'h0, 2'(i), es[i], 8'h00});
            rdchk("ea", CRM_OFF_EA, {16'h0, ee[i]});
        end
        $display("test index done");
        axi_wr(CRM_OFF_P, 32'h0);
        rdchk("status", CRM_OFF_P, 32'h20);
        axi_wr(CRM_OFF_A, 32'h7f);
        for (int i = 0; i < 5; i++) begin
            axi_wr(CRM_OFF_OP, {24'h0, ow[i]});
            rdchk("acc", CRM_OFF_A, {24'h0, oa[i]});
            rdchk("flags", CRM_OFF_P, {24'h0, opf[i]});
        end
        axi_wr(CRM_OFF_OP, 32'h1000_9009);
        rdchk("pc", CRM_OFF_PC, 32'h4245);
        axi_wr(CRM_OFF_OP, 32'h1000_1009);
        rdchk("pc", CRM_OFF_PC, 32'h4245);
        $display("test alu done");
        axi_wr(CRM_OFF_A, 32'h5a);
        axi_wr(CRM_OFF_OP, 32'h6);
        chk("stack", 32'h5a, {24'h0, mem_u.mem[16'h01ff]});
        rdchk("sp", CRM_OFF_S, 32'hfe);
        axi_wr(CRM_OFF_A, 32'h0);
        axi_wr(CRM_OFF_OP, 32'h7);
        rdchk("acc", CRM_OFF_A, 32'h5a);
        rdchk("sp", CRM_OFF_S, 32'hff);
        axi_wr(CRM_OFF_P, 32'h01);
        axi_wr(CRM_OFF_OP, 32'ha);
        // the three pushes land after the write answer
        repeat (3) @(posedge aclk);
        chk("pch", 32'h42, {24'h0, mem_u.mem[16'h01ff]});
        chk("pcl", 32'h45, {24'h0, mem_u.mem[16'h01fe]});
        chk("pushed p", 32'h31, {24'h0, mem_u.mem[16'h01fd]});
        rdchk("sp", CRM_OFF_S, 32'hfc);
        rdchk("pc", CRM_OFF_PC, {16'h0, CRM_VEC_BRK});
        rdchk("mask", CRM_OFF_P, 32'h04, 32'h04);
        rdchk("stat", CRM_OFF_STAT, 32'h5);
        axi_wr(CRM_OFF_PC, 32'h4300);
        irq_request <= 1'b1;
        repeat (10) @(posedge aclk);
        rdchk("sp", CRM_OFF_S, 32'hfc);
        axi_wr(CRM_OFF_P, 32'h01);
        repeat (10) @(posedge aclk);
        irq_request <= 1'b0;
        chk("pch", 32'h43, {24'h0, mem_u.mem[16'h01fc]});
        chk("pcl", 32'h00, {24'h0, mem_u.mem[16'h01fb]});
        chk("pushed p", 32'h21, {24'h0, mem_u.mem[16'h01fa]});
        rdchk("pc", CRM_OFF_PC, {16'h0, CRM_VEC_IRQ});
        rdchk("stat", CRM_OFF_STAT, 32'h1);
        $display("test entry done");
        for (int i = 0; i < 6; i++) begin
            axi_wr(CRM_OFF_OP, {24'h0, fc[i]});
            rdchk("flags", CRM_OFF_P, {24'h0, fp[i]}, 32'hef);
        end
        rdchk("sp", CRM_OFF_S, 32'hf9);
        axi_wr(CRM_OFF_OP, 32'hd);
        axi_wr(CRM_OFF_OP, 32'hb);
        repeat (3) @(posedge aclk);
        chk("pushed p", 32'h21, {24'h0, mem_u.mem[16'h01f7]});
        rdchk("sp", CRM_OFF_S, 32'hf6);
        axi_wr(CRM_OFF_STAT, 32'h1, CRM_RESP_ERR);
        axi_wr(8'h24, 32'h0, CRM_RESP_ERR);
        rdchk("unmapped", 8'h24, 32'h0, 32'hffffffff, CRM_RESP_ERR);
        $display("test flags done");
        do_reset(2);
        $display("test rereset done");
        print_verdict();
    end
endmodule
